// *** logic/sbtap_fifo2.sv ***
/*
  small valid/ready buffer held in flip-flops, two entries by default.
  assumes both sides run on the same clock; no crossing inside.
*/
`timescale 1ns/10ps
module sbtap_fifo2 #(
  parameter int W = 3, // word width
  parameter int DEPTH = 2 // entries, a power of two
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
  localparam int CW = $clog2(DEPTH + 1); // count width
  localparam logic [CW-1:0] FULL = CW'(DEPTH); // count when full

  logic [W-1:0] mem_q [DEPTH]; // storage entries
  logic [AW-1:0] wr_q; // write index
  logic [AW-1:0] rd_q; // read index
  logic [CW-1:0] cnt_q; // words held
  logic push; // word accepted
  logic pop; // word delivered

  // honest flags straight from the count
  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1; // wraps, depth is a power of two
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// *** logic/sbtap_pkg.sv ***
/*
  constants and types shared by the boundary scan test port of the
  pipelined memory: register sizes, cell positions, fixed capture
  patterns, instruction codes and the one-hot controller states.
  assumes a single 40 mhz system clock samples the serial test pins.
*/
package sbtap_pkg;

  // scan register sizes and cell positions
  localparam int IR_W = 3; // instruction register width
  localparam int ID_W = 32; // identification register width
  localparam int BSR_LEN = 89; // boundary cells, ball-grid package
  localparam int OE_CELL = 88; // cell #89, output-tristate control
  localparam int DQ_W = 36; // output data cells at the bottom of the ring

  // fixed codes and patterns
  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0; // external test code
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1; // low two bits are 01
  localparam logic [IR_W-1:0] IR_IDCODE_DEF = 3'h1; // default id code
  localparam logic [IR_W-1:0] IR_SAMPLEZ_DEF = 3'h2; // default high-z sample
  localparam logic [IR_W-1:0] IR_SAMPLE_DEF = 3'h4; // default sample/preload
  localparam logic [IR_W-1:0] IR_BYPASS_DEF = 3'h7; // all ones is bypass

  // arbitrary neutral identification value, lsb marks presence
  localparam logic [ID_W-1:0] ID_VALUE_DEF = 32'h1234_5679;

  // test controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, // test logic reset
    ST_IDLE = 16'h0002, // run test idle
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } sbtap_state_t;

endpackage

// *** logic/sbtap_top.sv ***
/*
  serial boundary scan test port of a pipelined memory: controller,
  instruction, bypass, identification and boundary scan registers,
  plus the output-pin override for external test and high-z sample.
  assumes the test clock, mode, data input and ring levels arrive
  from outside and are far slower than clk; the memory core drives
  core_out/core_oe and drains the instruction-update stream.
*/
`timescale 1ns/10ps

module sbtap_top
  import sbtap_pkg::*;
#(
  parameter logic [IR_W-1:0] IR_IDCODE = sbtap_pkg::IR_IDCODE_DEF,
  parameter logic [IR_W-1:0] IR_SAMPLEZ = sbtap_pkg::IR_SAMPLEZ_DEF,
  parameter logic [IR_W-1:0] IR_SAMPLE = sbtap_pkg::IR_SAMPLE_DEF,
  parameter logic [IR_W-1:0] IR_BYPASS = sbtap_pkg::IR_BYPASS_DEF,
  parameter logic [sbtap_pkg::ID_W-1:0] ID_VALUE = sbtap_pkg::ID_VALUE_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial test pins from the board controller
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // i/o ring levels seen by the boundary cells
  input wire logic [sbtap_pkg::BSR_LEN-1:0] ring_in,
  // functional output path from the memory core
  input wire logic [sbtap_pkg::DQ_W-1:0] core_out,
  input wire logic core_oe,
  // output pads
  output logic [sbtap_pkg::DQ_W-1:0] pin_out,
  output logic pin_oe,
  // stream of updated instructions to the core
  output logic upd_valid,
  input wire logic upd_ready,
  output logic [sbtap_pkg::IR_W-1:0] upd_ir
);

  import sbtap_pkg::*;

  // synchronisers, stage 1 is read only by stage 2
  logic tck_s1, tck_s2, tck_s3;
  logic tms_s1, tms_s2;
  logic tdi_s1, tdi_s2;
  logic [BSR_LEN-1:0] ring_s1, ring_s2;

  logic tck_rise; // one-cycle enable, rising test clock
  logic tck_fall; // one-cycle enable, falling test clock

  sbtap_state_t state_q, state_d; // controller state

  logic [IR_W-1:0] ir_q; // current instruction
  logic [IR_W-1:0] ir_sr; // instruction shift stage
  logic byp_q; // bypass bit
  logic [ID_W-1:0] id_sr; // identification shift path
  logic [BSR_LEN-1:0] bsr_sr; // boundary shift cells
  logic [BSR_LEN-1:0] bsr_lat; // boundary preload latches
  logic tdo_q, tdo_oe_q; // serial output flops
  logic [DQ_W-1:0] pin_out_q; // pad data flops
  logic pin_oe_q; // pad enable flop

  logic sel_bsr, sel_id; // data register selection
  logic mode_extest, mode_highz; // pin override modes
  logic dr_lsb; // lsb of the selected data register

  logic push_pend_q; // update word waiting for buffer room
  logic [IR_W-1:0] push_word_q; // word waiting
  logic push_ready; // buffer can take a word

  // two flops on every outside level before any logic looks at it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1; // pulled-up pin idles high
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      ring_s1 <= '0;
      ring_s2 <= '0;
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2; // delayed copy for edge finding
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
      ring_s1 <= ring_in;
      ring_s2 <= ring_s1;
    end
  end

  // tms and tdi share the tck pipeline depth, so they line up
  assign tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall = ~tck_s2 & tck_s3;

  // next controller state from tms
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: state_d = tms_s2 ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms_s2 ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_s2 ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s2 ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_d = tms_s2 ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms_s2 ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_d = tms_s2 ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_d = tms_s2 ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = tms_s2 ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_s2 ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s2 ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_d = tms_s2 ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms_s2 ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_d = tms_s2 ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_d = tms_s2 ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = tms_s2 ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET; // illegal code recovers to reset
    endcase
  end

  // controller advances on each test clock rise only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET; // power-up lands in test logic reset
    end else if (tck_rise) begin
      state_q <= state_d; // any state reaches reset in five tms-highs
    end
  end

  // selection decode; reserved codes fall back to bypass
  assign mode_extest = (ir_q == IR_EXTEST);
  assign mode_highz = (ir_q == IR_SAMPLEZ);
  assign sel_bsr = mode_extest | mode_highz | (ir_q == IR_SAMPLE);
  assign sel_id = (ir_q == IR_IDCODE);
  assign dr_lsb = sel_bsr ? bsr_sr[0] : (sel_id ? id_sr[0] : byp_q);

  // instruction register: capture, shift, update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_q <= IR_IDCODE;
      ir_sr <= IR_CAPTURE;
    end else if (state_q == ST_RESET) begin
      // held for the whole stay in reset, not just at a tck rise, so no
      // stale extest keeps driving pads while the controller sits there
      ir_q <= IR_IDCODE;
    end else if (tck_rise) begin
      if (state_q == ST_CAP_IR) begin
        ir_sr <= IR_CAPTURE;
      end else if (state_q == ST_SH_IR) begin
        ir_sr <= {tdi_s2, ir_sr[IR_W-1:1]}; // msb in, lsb out
      end
      if (state_q == ST_UPD_IR) begin
        ir_q <= ir_sr; // only now does it take effect
      end
    end
  end

  // bypass bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byp_q <= 1'b0;
    end else if (tck_rise && !sel_bsr && !sel_id) begin
      if (state_q == ST_CAP_DR) begin
        byp_q <= 1'b0;
      end else if (state_q == ST_SH_DR) begin
        byp_q <= tdi_s2;
      end
    end
  end

  // identification path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_sr <= '0;
    end else if (tck_rise && sel_id) begin
      if (state_q == ST_CAP_DR) begin
        id_sr <= ID_VALUE;
      end else if (state_q == ST_SH_DR) begin
        id_sr <= {tdi_s2, id_sr[ID_W-1:1]};
      end
    end
  end

  // boundary shift cells; ring levels are sampled, may be mid-change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_sr <= '0;
    end else if (tck_rise && sel_bsr) begin
      if (state_q == ST_CAP_DR) begin
        bsr_sr <= ring_s2; // all 89 pins at once
      end else if (state_q == ST_SH_DR) begin
        bsr_sr <= {tdi_s2, bsr_sr[BSR_LEN-1:1]};
      end
    end
  end

  // preload latches; shifting never disturbs them until update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_lat <= '0;
      bsr_lat[OE_CELL] <= 1'b1;
    end else if (state_q == ST_RESET) begin
      bsr_lat[OE_CELL] <= 1'b1; // level while in reset
    end else if (tck_rise && state_q == ST_UPD_DR && sel_bsr) begin
      bsr_lat <= bsr_sr;
    end
  end

  // serial output changes on the falling edge only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0; // undriven from power-up
    end else if (tck_fall) begin
      tdo_oe_q <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
      tdo_q <= (state_q == ST_SH_IR) ? ir_sr[0] : dr_lsb;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // pad override; the functional path is untouched otherwise, so a
  // port reset never interrupts memory cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_q <= '0;
      pin_oe_q <= 1'b0;
    end else if (mode_extest) begin
      pin_out_q <= bsr_lat[DQ_W-1:0];
      pin_oe_q <= bsr_lat[OE_CELL]; // one drives, zero floats
    end else if (mode_highz) begin
      pin_out_q <= core_out;
      pin_oe_q <= 1'b0; // held until another update or a reset
    end else begin
      pin_out_q <= core_out;
      pin_oe_q <= core_oe;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

  // each update-ir word waits here until the buffer has room; a second
  // update during a long stall replaces the waiting word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      push_pend_q <= 1'b0;
      push_word_q <= IR_IDCODE;
    end else if (tck_rise && state_q == ST_UPD_IR) begin
      push_pend_q <= 1'b1; // set wins over the drain
      push_word_q <= ir_sr;
    end else if (push_ready) begin
      push_pend_q <= 1'b0;
    end
  end

  // two entries plus the waiting word, so a core stall loses no word until a fourth update replaces the waiting one
  sbtap_fifo2 #(
    .W(IR_W),
    .DEPTH(2)
  ) u_upd_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(push_pend_q),
    .in_ready(push_ready),
    .in_data(push_word_q),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data(upd_ir)
  );

endmodule

// *** test/sbtap_bench.sv ***
/*
  self-checking bench: a table of instruction and scan cases, then
  port reset and update-stream stall by hand.
  assumes sbtap_ctl as controller and the bound checker.
*/
`timescale 1ns/10ps
module sbtap_bench;
  import sbtap_pkg::*;
  typedef struct {
    logic [2:0] ir; // instruction loaded
    int n; // data scan length
    logic [88:0] din; // bits shifted in
    logic [88:0] exp; // bits expected out
    logic poe; // pad enable afterwards
    logic [35:0] pout; // pad data afterwards
  } sbtap_row_t;
  localparam logic [88:0] RING = 89'h1_2345_6789_abcd_ef01_2345_67;
  localparam logic [35:0] CORE = 36'h9_8765_4321;
  localparam logic [88:0] PRE = {1'b1, 52'h0, 36'h5_a5a5_a5a5};
  localparam logic [88:0] PRE0 = {1'b0, 52'h0, 36'h0_ffff_0000};
  localparam logic [88:0] IDV = {57'h0, ID_VALUE_DEF};
  sbtap_row_t rows [9] = '{
    '{3'h1, 32, 89'h0, IDV, 1'b1, CORE}, // id value
    '{3'h7, 8, 89'hb4, 89'h68, 1'b1, CORE}, // bypass
    '{3'h7, 8, 89'h4b, 89'h96, 1'b1, CORE}, // bypass, no reserved code
    '{3'h1, 8, 89'hff, 89'h79, 1'b1, CORE}, // short id read
    '{3'h7, 3, 89'h5, 89'h2, 1'b1, CORE}, // short bypass
    '{3'h2, 89, 89'h0, RING, 1'b0, CORE}, // high-z
    '{3'h4, 89, PRE, RING, 1'b1, CORE}, // preload
    '{3'h0, 89, PRE, RING, 1'b1, PRE[35:0]}, // drive
    '{3'h0, 89, PRE0, RING, 1'b0, PRE0[35:0]} // off
  };
  logic [2:0] codes [3] = '{3'h7, 3'h2, 3'h4}; // stream words
  logic clk, rst, tck, tms, tdi, tdo, tdo_oe;
  logic [88:0] ring_in, dout;
  logic [35:0] core_out, pin_out;
  logic core_oe, pin_oe, upd_valid, upd_ready;
  logic [2:0] upd_ir;
  int n_mismatch, total_checks;

  sbtap_top i_dut (.clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .ring_in, .core_out, .core_oe, .pin_out, .pin_oe, .upd_valid,
    .upd_ready, .upd_ir);
  sbtap_ctl i_ctl (.clk, .tck, .tms, .tdi, .tdo, .tdo_oe);

  always #12.5 clk = ~clk; // 40 mhz

  // compare, count, report at once
  task automatic chk(input logic [88:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // the one place the run ends
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, several times the 0.126 ms the scans need
  initial begin
    #1_000_000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ring_in = RING;
    core_out = CORE;
    core_oe = 1'b1;
    upd_ready = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(tdo_oe, 1'b0);
    chk(pin_out, CORE);
    i_ctl.tms_reset();
    // table: load, check capture pattern, scan data, check pads
    foreach (rows[k]) begin
      i_ctl.scan(1'b1, 3, {86'h0, rows[k].ir}, dout);
      chk(dout[1:0], 2'b01);
      i_ctl.scan(1'b0, rows[k].n, rows[k].din, dout);
      chk(dout & ((89'h1 << rows[k].n) - 1), rows[k].exp);
      repeat (2) @(posedge clk);
      chk(pin_oe, rows[k].poe);
      chk(pin_out, rows[k].pout);
    end
    chk(i_ctl.oe_bad, 1'b0);
    // port reset from extest with the control cell cleared
    core_out <= 36'h1_0203_0405;
    i_ctl.tms_reset();
    chk(pin_out, 36'h1_0203_0405);
    chk(pin_oe, 1'b1);
    core_oe <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pin_oe, 1'b0);
    core_oe <= 1'b1;
    i_ctl.scan(1'b0, 32, 89'h0, dout);
    chk(dout[31:0], ID_VALUE_DEF);
    i_ctl.scan(1'b1, 3, 89'h0, dout);
    repeat (2) @(posedge clk);
    chk(pin_oe, 1'b1);
    chk(pin_out, PRE0[35:0]);
    // stall the stream: two buffered plus one pending
    upd_ready <= 1'b0;
    foreach (codes[k]) i_ctl.scan(1'b1, 3, {86'h0, codes[k]}, dout);
    chk(upd_valid, 1'b1);
    foreach (codes[k]) begin
      chk(upd_ir, codes[k]);
      upd_ready <= 1'b1;
      @(posedge clk);
      upd_ready <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk(upd_valid, 1'b0);
    end_sim;
  end
endmodule

// *** test/sbtap_chk.sv ***
/*
  concurrent checks on the test port pins and the update stream.
  assumes one clk domain; bound to every sbtap_top below.
*/
`timescale 1ns/10ps
module sbtap_chk
  import sbtap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  // pads and stream
  input wire logic pin_oe,
  input wire logic upd_valid,
  input wire logic upd_ready,
  input wire logic [sbtap_pkg::IR_W-1:0] upd_ir
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // serial output only moves in the low phase
  tdo_edge_a: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  tdo_hold_a: assert property ($changed(tdo) |=> $stable(tdo)[*5])
    else $error("tdo moved twice in one tck period");
  oe_edge_a: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo enable moved while tck high");
  // a shift state lasts at least one whole tck period
  oe_hold_a: assert property ($rose(tdo_oe) |-> tdo_oe[*6])
    else $error("tdo enable dropped early");
  rst_release_a: assert property ($fell(rst) |->
    !tdo_oe && !upd_valid)
    else $error("driver or stream active out of reset");
  // a stalled word is neither lost nor changed
  upd_hold_a: assert property (upd_valid && !upd_ready |=>
    upd_valid && $stable(upd_ir))
    else $error("stalled update word changed");
  upd_drop_a: assert property ($fell(upd_valid) |-> $past(upd_ready))
    else $error("update word vanished untaken");
  upd_quiet_a: assert property ($rose(upd_valid) |-> !tdo_oe)
    else $error("update during a shift");

  cover property ($rose(tdo_oe));
  cover property (upd_valid && !upd_ready);
  cover property ($fell(pin_oe));
endmodule

bind sbtap_top sbtap_chk i_chk (.clk, .rst, .tck, .tdo, .tdo_oe,
  .pin_oe, .upd_valid, .upd_ready, .upd_ir);

// *** test/sbtap_ctl.sv ***
/*
  board test controller model: makes tck, tms and tdi, reads tdo.
  assumes a 40 mhz clk paces it; 4 clk per tck phase.
*/
`timescale 1ns/10ps
module sbtap_ctl (
  // pacing clock
  input wire logic clk,
  // serial pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic oe_bad; // enable seen wrong at some step

  // tck idles low until the first step and then rests high between steps;
  // tms and tdi sit at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    oe_bad = 1'b0;
  end

  // one 200 ns period, under the 20 mhz limit
  task automatic step(input logic m, d, sh, output logic o);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1; // inputs settled 4 clk before the rise
    repeat (4) @(posedge clk);
    o = tdo_oe ? tdo : ~tdo; // a released line reads as the inverse of tdo, not held
    if (tdo_oe !== sh) oe_bad = 1'b1;
  endtask

  // five high rises, then idle
  task automatic tms_reset;
    logic o;
    repeat (5) step(1'b1, 1'b1, 1'b0, o);
    step(1'b0, 1'b1, 1'b0, o);
  endtask

  // idle to capture, shift n bits, update, idle again
  task automatic scan(input logic ir, input int n,
      input logic [88:0] din, output logic [88:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b1, 1'b0, o);
    step(1'b0, 1'b1, 1'b0, o);
    step(1'b0, 1'b1, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, o); // lsb out first
      dout[i] = o;
    end
    step(1'b1, 1'b1, 1'b0, o);
    step(1'b0, 1'b1, 1'b0, o);
  endtask
endmodule
